// *** rtl/rsg_gain_cal.sv ***
// Purpose: receiver gain control loop, filter fine calibration and clock derivation
// Assumes: clk is the crystal reference; strength_in is synchronous to clk
// Notes:   registers over APB, zero wait states
//
// Behaviour
// RL1: amplifier disconnected during fine calibration; only the tones feed the chain.
// RL2: calibration trims filter centre toward equal tone attenuation over ten measurements.
// RL3: each tone has an 8-bit divider; tone is crystal over twice divider.
// RL4: host places tones near 65.8 kHz and 131.5 kHz.
// RL5: each adjust-and-measure step lasts dwell sequencer periods; ten steps total.
// RL6: host picks dwell giving at least 500 us per step.
// RL7: strength level is an 80-level 7-bit code for readback and gain loop.
// RL8: gain control is on by default after reset.
// RL9: gain drops above the upper limit, rises below the lower limit.
// RL10: lower limit resets to 30, upper limit to 70.
// RL11: host keeps its two limits more than 30 apart.
// RL12: offset clock is crystal over 4, 8, 16 or 32 by 2-bit field.
// RL13: after each gain change wait one update period; rate is sequencer over divide.
// RL14: host sets gain divide 10 with a 100 kHz sequencer clock.
// RL15: the loop walks at most five gain settings.
// RL16: host may disable gain control and set amp mode, gain, mixer linearity.
// RL17: status readback gives strength code, amp gain and filter gain in use.
// RL18: gain codes read high 10, medium 01, low 00.
// RL19: host computes input power from code and gain correction.
// RL20: between limits inclusive the gain stays unchanged.
// RL21: gain loop sets filter gain itself; when off a 2-bit field does.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "rsg_defs.svh"
module rsg_gain_cal (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  strength_in,
  output logic             amp_connect,
  output logic             tone_lower_out,
  output logic             tone_upper_out,
  output logic             offset_clock,
  output logic [1:0]       amp_gain,
  output logic [1:0]       if_gain,
  output logic             amp_mode_sel,
  output logic             mixer_linearity,
  output logic [7:0]       if_centre_trim,
  output logic             cal_busy
);

  localparam rsg_pkg::rsg_state_t RST_VAL = '{
    agc_en:       1'b1,
    amp_mode:     1'b0,
    mix_lin:      1'b0,
    amp_gain_sel: `RSG_GAIN_HIGH,
    if_gain_sel:  `RSG_GAIN_HIGH,
    lower_lim:    `RSG_RST_LOWER,
    upper_lim:    `RSG_RST_UPPER,
    ofs_div:      `RSG_RST_OFS_DIV,
    seq_div:      `RSG_RST_SEQ_DIV,
    gain_div:     `RSG_RST_GAIN_DIV,
    tone_lo_div:  `RSG_RST_TONE_LO,
    tone_hi_div:  `RSG_RST_TONE_HI,
    dwell:        `RSG_RST_DWELL,
    code:         7'h00,
    gain_idx:     3'h0,
    cal_st:       rsg_pkg::CAL_IDLE,
    dwell_cnt:    16'h0000,
    step_cnt:     4'h0,
    meas_lo:      7'h00,
    trim:         `RSG_RST_TRIM,
    cal_done:     1'b0,
    prdata:       32'h0000_0000,
    pslverr:      1'b0
  };

  rsg_pkg::rsg_state_t st_ff;
  rsg_pkg::rsg_state_t nxt_st;

  logic       seq_tick;
  logic       gain_tick;
  logic       in_cal;
  logic       agc_run;
  logic [1:0] agc_amp_gain;
  logic [1:0] agc_if_gain;
  logic [7:0] ofs_half;
  logic [6:0] code_sat;
  logic [15:0] dwell_half;
  logic [15:0] cnt_next;
  logic       setup_ph;
  logic       wr_access;
  logic       addr_ok;

  assign in_cal   = (st_ff.cal_st != rsg_pkg::CAL_IDLE);
  assign agc_run  = st_ff.agc_en && !in_cal;
  assign cal_busy = in_cal;

  // sequencer clock tick from the crystal
  rsg_divider #(
    .W (8)
  ) u_seq_div (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (1'b1),
    .div   (st_ff.seq_div),
    .tick  (seq_tick)
  );

  // gain update tick; pauses and keeps its count while the loop is held
  rsg_divider #(
    .W (6)
  ) u_gain_div (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (seq_tick && agc_run),
    .div   (st_ff.gain_div),
    .tick  (gain_tick)
  ); // [RL13]

  // offset clock: half period 2, 4, 8 or 16 crystal cycles
  assign ofs_half = `RSG_OFS_HALF_BASE << st_ff.ofs_div; // [RL12]

  rsg_square u_ofs_clk (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (1'b1),
    .half  (ofs_half),
    .wave  (offset_clock)
  ); // [RL12]

  // one tone at a time so each is measured alone
  rsg_square u_tone_lo (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (st_ff.cal_st == rsg_pkg::CAL_LOWER),
    .half  (st_ff.tone_lo_div),
    .wave  (tone_lower_out)
  ); // [RL3]

  rsg_square u_tone_hi (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (st_ff.cal_st == rsg_pkg::CAL_UPPER),
    .half  (st_ff.tone_hi_div),
    .wave  (tone_upper_out)
  ); // [RL3]

  assign amp_connect = !in_cal; // [RL1]

  // gain pair of each loop setting, highest gain first
  always_comb begin
    case (st_ff.gain_idx)
      3'h0: begin
        agc_amp_gain = `RSG_GAIN_HIGH;
        agc_if_gain  = `RSG_GAIN_HIGH;
      end
      3'h1: begin
        agc_amp_gain = `RSG_GAIN_MED;
        agc_if_gain  = `RSG_GAIN_HIGH;
      end
      3'h2: begin
        agc_amp_gain = `RSG_GAIN_MED;
        agc_if_gain  = `RSG_GAIN_MED;
      end
      3'h3: begin
        agc_amp_gain = `RSG_GAIN_MED;
        agc_if_gain  = `RSG_GAIN_LOW;
      end
      default: begin
        agc_amp_gain = `RSG_GAIN_LOW;
        agc_if_gain  = `RSG_GAIN_LOW;
      end
    endcase
  end // [RL15] [RL18]

  assign amp_gain        = st_ff.agc_en ? agc_amp_gain : st_ff.amp_gain_sel; // [RL16]
  assign if_gain         = st_ff.agc_en ? agc_if_gain : st_ff.if_gain_sel; // [RL21]
  assign amp_mode_sel    = st_ff.amp_mode; // [RL16]
  assign mixer_linearity = st_ff.mix_lin; // [RL16]
  assign if_centre_trim  = st_ff.trim;

  // clamp to the 80 levels
  assign code_sat = (strength_in > `RSG_LEVEL_MAX) ? `RSG_LEVEL_MAX : strength_in; // [RL7]

  assign dwell_half = st_ff.dwell >> 1;
  assign cnt_next   = st_ff.dwell_cnt + 16'h0001;

  // apb phases; zero wait states
  assign setup_ph  = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign addr_ok   = (paddr[1:0] == 2'h0) && (paddr <= `RSG_ADDR_STATUS);
  assign pready    = 1'b1;
  assign prdata    = st_ff.prdata;
  assign pslverr   = st_ff.pslverr;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.code = code_sat; // [RL7]

    // gain loop
    if (gain_tick) begin
      if ((st_ff.code > st_ff.upper_lim) && (st_ff.gain_idx < `RSG_GAIN_IDX_MAX)) begin
        nxt_st.gain_idx = st_ff.gain_idx + 3'h1; // [RL9]
      end else if ((st_ff.code < st_ff.lower_lim) && (st_ff.gain_idx != 3'h0)) begin
        nxt_st.gain_idx = st_ff.gain_idx - 3'h1; // [RL9]
      end
      // inside the limits the setting is held [RL20]
    end

    // fine calibration steps
    case (st_ff.cal_st)
      rsg_pkg::CAL_IDLE: begin
        nxt_st.dwell_cnt = 16'h0000;
      end
      rsg_pkg::CAL_LOWER: begin
        if (seq_tick) begin
          nxt_st.dwell_cnt = cnt_next; // [RL5]
          if (cnt_next >= dwell_half) begin
            nxt_st.meas_lo = st_ff.code; // [RL2]
            nxt_st.cal_st  = rsg_pkg::CAL_UPPER;
          end
        end
      end
      rsg_pkg::CAL_UPPER: begin
        if (seq_tick) begin
          nxt_st.dwell_cnt = cnt_next;
          if (cnt_next >= st_ff.dwell) begin // [RL5]
            // lower tone stronger means centre sits low
            if ((st_ff.meas_lo > st_ff.code) && (st_ff.trim != `RSG_TRIM_MAX)) begin
              nxt_st.trim = st_ff.trim + 8'h01; // [RL2]
            end else if ((st_ff.meas_lo < st_ff.code) && (st_ff.trim != `RSG_TRIM_MIN)) begin
              nxt_st.trim = st_ff.trim - 8'h01; // [RL2]
            end
            nxt_st.step_cnt  = st_ff.step_cnt + 4'h1;
            nxt_st.dwell_cnt = 16'h0000;
            if (st_ff.step_cnt + 4'h1 >= `RSG_CAL_STEPS) begin
              nxt_st.cal_st   = rsg_pkg::CAL_IDLE; // [RL5]
              nxt_st.cal_done = 1'b1;
            end else begin
              nxt_st.cal_st = rsg_pkg::CAL_LOWER;
            end
          end
        end
      end
      default: begin
        nxt_st.cal_st = rsg_pkg::CAL_IDLE;
      end
    endcase

    // read data and error latched in the setup phase
    if (setup_ph) begin
      nxt_st.prdata  = 32'h0000_0000;
      nxt_st.pslverr = !addr_ok;
      if (!pwrite) begin
        case (paddr)
          `RSG_ADDR_CTRL: begin
            nxt_st.prdata[`RSG_CTRL_AGC_EN]       = st_ff.agc_en;
            nxt_st.prdata[`RSG_CTRL_AMP_MODE]     = st_ff.amp_mode;
            nxt_st.prdata[`RSG_CTRL_MIX_LIN]      = st_ff.mix_lin;
            nxt_st.prdata[`RSG_CTRL_AMP_GAIN +: 2] = st_ff.amp_gain_sel;
            nxt_st.prdata[`RSG_CTRL_IF_GAIN +: 2] = st_ff.if_gain_sel;
          end
          `RSG_ADDR_THRESH: begin
            nxt_st.prdata[`RSG_THR_LOWER +: 7] = st_ff.lower_lim;
            nxt_st.prdata[`RSG_THR_UPPER +: 7] = st_ff.upper_lim;
          end
          `RSG_ADDR_CLKDIV: begin
            nxt_st.prdata[`RSG_DIV_OFFSET +: 2] = st_ff.ofs_div;
            nxt_st.prdata[`RSG_DIV_SEQ +: 8]    = st_ff.seq_div;
            nxt_st.prdata[`RSG_DIV_GAIN +: 6]   = st_ff.gain_div;
          end
          `RSG_ADDR_TONE: begin
            nxt_st.prdata[`RSG_TONE_LOWER +: 8] = st_ff.tone_lo_div;
            nxt_st.prdata[`RSG_TONE_UPPER +: 8] = st_ff.tone_hi_div;
            nxt_st.prdata[`RSG_TONE_DWELL +: 16] = st_ff.dwell;
          end
          `RSG_ADDR_STATUS: begin
            nxt_st.prdata[`RSG_STAT_CODE +: 7]     = st_ff.code; // [RL17]
            nxt_st.prdata[`RSG_STAT_AMP_GAIN +: 2] = amp_gain; // [RL17]
            nxt_st.prdata[`RSG_STAT_IF_GAIN +: 2]  = if_gain; // [RL17]
            nxt_st.prdata[`RSG_STAT_BUSY]          = in_cal;
            nxt_st.prdata[`RSG_STAT_DONE]          = st_ff.cal_done;
            nxt_st.prdata[`RSG_STAT_STEP +: 4]     = st_ff.step_cnt;
            nxt_st.prdata[`RSG_STAT_TRIM +: 8]     = st_ff.trim;
          end
          default: begin
            nxt_st.prdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // writes take effect in the access phase
    if (wr_access && addr_ok) begin
      case (paddr)
        `RSG_ADDR_CTRL: begin
          nxt_st.agc_en       = pwdata[`RSG_CTRL_AGC_EN]; // [RL16]
          nxt_st.amp_mode     = pwdata[`RSG_CTRL_AMP_MODE];
          nxt_st.mix_lin      = pwdata[`RSG_CTRL_MIX_LIN];
          nxt_st.amp_gain_sel = pwdata[`RSG_CTRL_AMP_GAIN +: 2];
          nxt_st.if_gain_sel  = pwdata[`RSG_CTRL_IF_GAIN +: 2]; // [RL21]
          if (pwdata[`RSG_CTRL_CAL_START] && !in_cal) begin
            nxt_st.cal_st    = rsg_pkg::CAL_LOWER; // [RL1]
            nxt_st.dwell_cnt = 16'h0000;
            nxt_st.step_cnt  = 4'h0;
            nxt_st.cal_done  = 1'b0;
          end
        end
        `RSG_ADDR_THRESH: begin
          nxt_st.lower_lim = pwdata[`RSG_THR_LOWER +: 7]; // [RL9]
          nxt_st.upper_lim = pwdata[`RSG_THR_UPPER +: 7];
        end
        `RSG_ADDR_CLKDIV: begin
          nxt_st.ofs_div  = pwdata[`RSG_DIV_OFFSET +: 2];
          nxt_st.seq_div  = pwdata[`RSG_DIV_SEQ +: 8];
          nxt_st.gain_div = pwdata[`RSG_DIV_GAIN +: 6];
        end
        `RSG_ADDR_TONE: begin
          nxt_st.tone_lo_div = pwdata[`RSG_TONE_LOWER +: 8];
          nxt_st.tone_hi_div = pwdata[`RSG_TONE_UPPER +: 8];
          nxt_st.dwell       = pwdata[`RSG_TONE_DWELL +: 16];
        end
        default: begin
          // status is read-only; a done flag set by calibration in this cycle stands
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= RST_VAL; // [RL8] [RL10]
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : rsg_gain_cal

// *** rtl/rsg_defs.svh ***
// Purpose: register map, field positions, reset values and counts of the gain/calibration block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef RSG_DEFS_SVH
`define RSG_DEFS_SVH

// register byte addresses
`define RSG_ADDR_CTRL      8'h00
`define RSG_ADDR_THRESH    8'h04
`define RSG_ADDR_CLKDIV    8'h08
`define RSG_ADDR_TONE      8'h0c
`define RSG_ADDR_STATUS    8'h10

// control register fields
`define RSG_CTRL_AGC_EN    0
`define RSG_CTRL_CAL_START 1
`define RSG_CTRL_AMP_MODE  2
`define RSG_CTRL_MIX_LIN   3
`define RSG_CTRL_AMP_GAIN  4
`define RSG_CTRL_IF_GAIN   6

// threshold register fields
`define RSG_THR_LOWER      0
`define RSG_THR_UPPER      8

// divider register fields
`define RSG_DIV_OFFSET     0
`define RSG_DIV_SEQ        8
`define RSG_DIV_GAIN       16

// tone register fields
`define RSG_TONE_LOWER     0
`define RSG_TONE_UPPER     8
`define RSG_TONE_DWELL     16

// status register fields
`define RSG_STAT_CODE      0
`define RSG_STAT_AMP_GAIN  8
`define RSG_STAT_IF_GAIN   10
`define RSG_STAT_BUSY      12
`define RSG_STAT_DONE      13
`define RSG_STAT_STEP      16
`define RSG_STAT_TRIM      24

// reset values
`define RSG_RST_LOWER      7'h1e
`define RSG_RST_UPPER      7'h46
`define RSG_RST_SEQ_DIV    8'h64
`define RSG_RST_GAIN_DIV   6'h0a
`define RSG_RST_OFS_DIV    2'h1
`define RSG_RST_TONE_LO    8'h4c
`define RSG_RST_TONE_HI    8'h26
`define RSG_RST_DWELL      16'h0032
`define RSG_RST_TRIM       8'h80

// fixed counts and codes
`define RSG_CAL_STEPS      4'ha
`define RSG_LEVEL_MAX      7'h4f
`define RSG_GAIN_IDX_MAX   3'h4
`define RSG_GAIN_HIGH      2'h2
`define RSG_GAIN_MED       2'h1
`define RSG_GAIN_LOW       2'h0
`define RSG_TRIM_MAX       8'hff
`define RSG_TRIM_MIN       8'h00
`define RSG_OFS_HALF_BASE  8'h02

`endif

// *** rtl/rsg_pkg.sv ***
// Purpose: types of the gain/calibration block
// Assumes: nothing
// Notes:   all state of the top is one packed struct
package rsg_pkg;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_LOWER,
    CAL_UPPER
  } rsg_cal_state_t;

  typedef struct packed {
    logic           agc_en;
    logic           amp_mode;
    logic           mix_lin;
    logic [1:0]     amp_gain_sel;
    logic [1:0]     if_gain_sel;
    logic [6:0]     lower_lim;
    logic [6:0]     upper_lim;
    logic [1:0]     ofs_div;
    logic [7:0]     seq_div;
    logic [5:0]     gain_div;
    logic [7:0]     tone_lo_div;
    logic [7:0]     tone_hi_div;
    logic [15:0]    dwell;
    logic [6:0]     code;
    logic [2:0]     gain_idx;
    rsg_cal_state_t cal_st;
    logic [15:0]    dwell_cnt;
    logic [3:0]     step_cnt;
    logic [6:0]     meas_lo;
    logic [7:0]     trim;
    logic           cal_done;
    logic [31:0]    prdata;
    logic           pslverr;
  } rsg_state_t;

endpackage : rsg_pkg

// *** rtl/rsg_divider.sv ***
// Purpose: programmable tick divider, one tick every div enabled cycles
// Assumes: div of zero behaves as one
// Notes:   tick is combinational from the counter
`timescale 1ns/100ps
module rsg_divider #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } rsg_div_state_t;

  rsg_div_state_t st_ff;
  rsg_div_state_t nxt_st;
  logic           wrap;

  always_comb begin
    nxt_st = st_ff;
    wrap   = (div == '0) || (st_ff.cnt >= div - W'(1));
    tick   = en && wrap;
    if (en) begin
      nxt_st.cnt = wrap ? '0 : st_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : rsg_divider

// *** rtl/rsg_square.sv ***
// Purpose: square wave that toggles every half enabled cycles
// Assumes: half of zero behaves as one
// Notes:   output low and counter cleared while disabled
`timescale 1ns/100ps
module rsg_square (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic [7:0] half,
  output logic            wave
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       wave;
  } rsg_sq_state_t;

  rsg_sq_state_t st_ff;
  rsg_sq_state_t nxt_st;

  assign wave = st_ff.wave;

  always_comb begin
    nxt_st = st_ff;
    if (!en) begin
      nxt_st = '0;
    end else if ((half == 8'h00) || (st_ff.cnt >= half - 8'h01)) begin
      nxt_st.cnt  = 8'h00;
      nxt_st.wave = !st_ff.wave;
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : rsg_square

// *** verification/rsg_gain_cal_sva.sv ***
// Purpose: port checks of the gain/calibration block
// Assumes: sees only top ports
// Notes:   bound below
`timescale 1ns/100ps
`include "rsg_defs.svh"
module rsg_gain_cal_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        amp_connect,
  input wire logic        tone_lower_out,
  input wire logic        tone_upper_out,
  input wire logic        offset_clock,
  input wire logic [1:0]  amp_gain,
  input wire logic [1:0]  if_gain,
  input wire logic        amp_mode_sel,
  input wire logic        mixer_linearity,
  input wire logic [7:0]  if_centre_trim,
  input wire logic        cal_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == `RSG_ADDR_CTRL;
  a_amp_off_cal: assert property (cal_busy |-> !amp_connect)
    else $error("amplifier connected during calibration");
  a_tones_idle: assert property (!cal_busy && !$past(cal_busy) |-> !tone_lower_out && !tone_upper_out)
    else $error("tone active outside calibration");
  a_tones_apart: assert property (tone_upper_out |-> !tone_lower_out)
    else $error("both tones active");
  a_cal_start: assert property (ctrl_wr && pwdata[`RSG_CTRL_CAL_START] && !cal_busy
    |=> cal_busy && !amp_connect)
    else $error("calibration did not start");
  a_mode_pins: assert property (ctrl_wr |=> amp_mode_sel == $past(pwdata[2])
    && mixer_linearity == $past(pwdata[3]))
    else $error("mode pins differ from control write");
  a_gain_codes: assert property (amp_gain != 2'h3 && if_gain != 2'h3)
    else $error("illegal gain code");
  a_trim_busy: assert property ($changed(if_centre_trim) |-> $past(cal_busy) || $past(cal_busy, 2))
    else $error("trim moved outside calibration");
  a_trim_step: assert property ($changed(if_centre_trim) |-> if_centre_trim - $past(if_centre_trim)
    == 8'h01 || $past(if_centre_trim) - if_centre_trim == 8'h01)
    else $error("trim moved by more than one");
  a_offset_hold: assert property ($changed(offset_clock) |=> $stable(offset_clock))
    else $error("offset clock half period below two");
  cover property ($rose(cal_busy));
  cover property ($changed(amp_gain));
  cover property ($changed(if_centre_trim));
endmodule : rsg_gain_cal_chk
bind rsg_gain_cal rsg_gain_cal_chk rsg_gain_cal_chk_inst (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .amp_connect, .tone_lower_out, .tone_upper_out, .offset_clock, .amp_gain,
  .if_gain, .amp_mode_sel, .mixer_linearity, .if_centre_trim, .cal_busy);

// *** verification/rsg_gain_cal_tb_top.sv ***
// Purpose: self-checking bench of the gain/calibration block
// Assumes: APB register map of the defs header
// Notes:   sequencer sped up to one tick per clock
`timescale 1ns/100ps
`include "rsg_defs.svh"
module rsg_gain_cal_tb_top;
  logic        clk = 1'b0, rst_n, psel, penable, pwrite, pready, pslverr, rerr, lo_ph;
  logic [7:0]  paddr, if_centre_trim;
  logic [31:0] pwdata, prdata, rdata;
  logic [6:0]  strength_in, str_set;
  logic        amp_connect, tone_lower_out, tone_upper_out, offset_clock;
  logic [1:0]  amp_gain, if_gain;
  logic        amp_mode_sel, mixer_linearity, cal_busy;
  int          error_cnt, tests_run, busy_n, run_l, run_u, max_l, max_u, n;
  logic [3:0]  walk [5] = '{4'ha, 4'h6, 4'h5, 4'h4, 4'h0};
  rsg_gain_cal rsg_gain_cal_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .strength_in, .amp_connect, .tone_lower_out, .tone_upper_out,
    .offset_clock, .amp_gain, .if_gain, .amp_mode_sel, .mixer_linearity, .if_centre_trim,
    .cal_busy);
  always #50 clk = ~clk;
  // strength follows the active tone phase during calibration
  always @(posedge clk) begin
    strength_in <= cal_busy ? (lo_ph ? 7'h28 : 7'h14) : str_set;
    lo_ph <= !cal_busy || tone_lower_out ? 1'b1 : (tone_upper_out ? 1'b0 : lo_ph);
    if (cal_busy) begin
      busy_n <= busy_n + 1;
      run_l <= tone_lower_out ? run_l + 1 : 0;
      run_u <= tone_upper_out ? run_u + 1 : 0;
    end
    max_l <= run_l > max_l ? run_l : max_l;
    max_u <= run_u > max_u ? run_u : max_u;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // gain correction of a read-back pair {amp, filter}
  function automatic int gain_corr(input logic [3:0] p);
    case (p)
      4'ha:    return 32'h00;
      4'h6:    return 32'h18;
      4'h5:    return 32'h26;
      4'h4:    return 32'h3a;
      4'h0:    return 32'h56;
      default: return 32'hffff;
    endcase
  endfunction : gain_corr
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) error_cnt++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_pair(input logic [3:0] e, output int c);
    c = 0;
    while ({amp_gain, if_gain} !== e && c < 300) begin
      // sample on the falling edge, where outputs are settled
      @(negedge clk);
      c++;
    end
    chk("gain pair", {28'h0, amp_gain, if_gain}, {28'h0, e});
  endtask : wait_pair
  task automatic wait_tog(output int c);
    logic v;
    v = offset_clock;
    c = 0;
    while (offset_clock === v && c < 200) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_tog
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    #(20000 * 100);
    error_cnt++;
    stop_test();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, str_set} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(`RSG_ADDR_THRESH, 1'b0, 32'h0);
    chk("limits", rdata, 32'h0000_461e);
    apb(`RSG_ADDR_CTRL, 1'b0, 32'h0);
    chk("agc on", {31'h0, rdata[0]}, 32'h1);
    chk("gain reset", {28'h0, amp_gain, if_gain}, 32'ha);
    apb(`RSG_ADDR_CLKDIV, 1'b0, 32'h0);
    chk("clkdiv", rdata, 32'h000a_6401);
    apb(`RSG_ADDR_TONE, 1'b0, 32'h0);
    chk("tone", rdata, 32'h0032_264c);
    apb(8'h14, 1'b0, 32'h0);
    chk("bad addr", {rdata[30:0], rerr}, 32'h1);
    $display("test reset done");
    apb(`RSG_ADDR_CLKDIV, 1'b1, 32'h0004_0101);
    str_set <= 7'h64;
    for (int i = 1; i < 5; i++) begin
      wait_pair(walk[i], n);
      if (i > 1) chk("step gap", 32'(n), 32'h4);
    end
    apb(`RSG_ADDR_STATUS, 1'b0, 32'h0);
    chk("status", rdata & 32'h0000_0fff, 32'h0000_004f);
    // twice the input power: code 79 plus low/low correction, minus 260
    chk("power", 32'(rdata[6:0]) + gain_corr({rdata[9:8], rdata[11:10]}) - 32'h104,
        32'hffff_ffa1);
    str_set <= 7'h46;
    repeat (40) @(posedge clk);
    chk("hold", {28'h0, amp_gain, if_gain}, 32'h0);
    str_set <= 7'h0a;
    for (int i = 3; i >= 0; i--) wait_pair(walk[i], n);
    $display("test gain loop done");
    for (int i = 0; i < 3; i++) begin
      apb(`RSG_ADDR_CTRL, 1'b1, 32'(i * 8'h50 + (i % 2) * 4 + (i / 2) * 8));
      @(posedge clk);
      chk("manual gain", {28'h0, amp_gain, if_gain}, 32'(i * 5));
      chk("mode pins", {30'h0, mixer_linearity, amp_mode_sel}, 32'(i));
    end
    apb(`RSG_ADDR_CTRL, 1'b1, 32'h1);
    $display("test manual done");
    apb(`RSG_ADDR_TONE, 1'b1, 32'h0010_0203);
    apb(`RSG_ADDR_CTRL, 1'b1, 32'h3);
    @(negedge clk);
    chk("amp off", {30'h0, amp_connect, cal_busy}, 32'h1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cal_busy !== 1'b0 && n < 400);
    repeat (2) @(posedge clk);
    chk("cal length", 32'(busy_n), 32'h0000_00a0);
    chk("amp on", {30'h0, amp_connect, cal_busy}, 32'h2);
    chk("lower tone half", 32'(max_l), 32'h3);
    chk("upper tone half", 32'(max_u), 32'h2);
    chk("trim", {24'h0, if_centre_trim}, 32'h8a);
    apb(`RSG_ADDR_STATUS, 1'b0, 32'h0);
    chk("cal status", rdata & 32'hff0f_3000, 32'h8a0a_2000);
    apb(`RSG_ADDR_THRESH, 1'b1, 32'h0000_3c14);
    apb(`RSG_ADDR_THRESH, 1'b0, 32'h0);
    chk("limits write", rdata, 32'h0000_3c14);
    $display("test calibration done");
    for (int c = 0; c < 4; c++) begin
      apb(`RSG_ADDR_CLKDIV, 1'b1, 32'h0004_0100 | 32'(c));
      repeat (3) wait_tog(n);
      chk("offset half", 32'(n), 32'(2 << c));
    end
    $display("test offset clock done");
    stop_test();
  end
endmodule : rsg_gain_cal_tb_top
